// ### hdl/tpdu_pkg.sv
// Purpose: shared constants and types of the trace and measurement debug unit
// Assumes: 100 MHz core clock, byte addressed register port
// Notes: trace records go out as a header nibble followed by payload nibbles, low first
package tpdu_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WIN_BASE = 8'h08;
  localparam logic [7:0] REG_WIN_STRIDE = 8'h0C;
  localparam logic [7:0] REG_PERF_COUNT = 8'h20;
  localparam logic [7:0] REG_LOST_COUNT = 8'h24;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] WIN_ADDR_RESET = 32'h0000_0000;
  localparam logic [2:0] WIN_CFG_RESET = 3'h6;
  // control field positions
  localparam int CTRL_BRANCH_EN = 0;
  localparam int CTRL_WIN_A_EN = 1;
  localparam int CTRL_WIN_B_EN = 2;
  localparam int CTRL_SW_EN = 3;
  localparam int CTRL_PROFILE_ON = 4;
  localparam int CTRL_MODE_LO = 5;
  localparam int CTRL_HALT_ON_EVENT = 7;
  localparam int CTRL_PERF_CLEAR = 8;
  // window config field positions
  localparam int WCFG_IBUS = 0;
  localparam int WCFG_READ = 1;
  localparam int WCFG_WRITE = 2;
  // status field positions
  localparam int STAT_PERF_ACTIVE = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_CLK_FAST = 2;
  localparam int STAT_HALT_REQ = 3;
  // compression match widths
  localparam int MATCH_HI4 = 28;
  localparam int MATCH_HI8 = 24;
  localparam int MATCH_HI16 = 16;
  // trace clock ceiling and derived least period in core cycles
  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int TRACE_CLK_MAX_MHZ = 50;
  localparam int TRACE_MIN_PERIOD_NS = 1000 / TRACE_CLK_MAX_MHZ;
  localparam logic [7:0] TRACE_MIN_PERIOD_CYC =
    8'((TRACE_MIN_PERIOD_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);
  // instructions that must retire between event match and halt
  localparam logic [1:0] HALT_DELAY_INSTR = 2'h2;
  localparam logic [4:0] SW_NIBBLES = 5'h10;

  typedef enum logic [1:0] {
    SZ_4 = 2'b00,
    SZ_8 = 2'b01,
    SZ_16 = 2'b10,
    SZ_32 = 2'b11
  } tpdu_size_t;

  typedef enum logic [1:0] {
    REC_BRANCH = 2'b00,
    REC_WIN_A = 2'b01,
    REC_WIN_B = 2'b10,
    REC_SOFT = 2'b11
  } tpdu_rtype_t;

  typedef enum logic [1:0] {
    MEAS_RUN_TO_BREAK = 2'b00,
    MEAS_EVENT2_TO_EVENT1 = 2'b01,
    MEAS_EVENT1_TO_EVENT2 = 2'b10,
    MEAS_RESERVED = 2'b11
  } tpdu_mode_t;

  typedef enum logic [1:0] {
    BR_DELAYED = 2'b00,
    BR_NON_DELAYED = 2'b01,
    BR_TRAP_ALWAYS = 2'b10,
    BR_EXCEPTION = 2'b11
  } tpdu_brkind_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic cacheHit;
    logic [31:0] addr;
  } tpdu_bus_t;

  typedef struct packed {
    logic valid;
    tpdu_brkind_t kind;
    logic completionExc;
    logic [31:0] srcAddr;
    logic [31:0] nextAddr;
  } tpdu_branch_t;

  typedef struct packed {
    tpdu_rtype_t rtype;
    tpdu_size_t size;
    logic [63:0] payload;
  } tpdu_rec_t;

  function automatic logic [4:0] sizeNibbles(input tpdu_size_t sz);
    case (sz)
      SZ_4: sizeNibbles = 5'h01;
      SZ_8: sizeNibbles = 5'h02;
      SZ_16: sizeNibbles = 5'h04;
      default: sizeNibbles = 5'h08;
    endcase
  endfunction
endpackage

// ### hdl/tpdu_addr_compress.sv
// Purpose: picks the shortest difference form of a trace address
// Assumes: reference address and its valid flag held by the caller
// Notes: purely combinational
module tpdu_addr_compress
  import tpdu_pkg::*;
(
  input wire logic [31:0] addr,
  input wire logic [31:0] refAddr,
  input wire logic refValid,
  output tpdu_size_t size
);
  wire logic hi28Eq = addr[31:32-MATCH_HI4] == refAddr[31:32-MATCH_HI4];
  wire logic hi24Eq = addr[31:32-MATCH_HI8] == refAddr[31:32-MATCH_HI8];
  wire logic hi16Eq = addr[31:32-MATCH_HI16] == refAddr[31:32-MATCH_HI16];

  assign size = !refValid ? SZ_32 :
                hi28Eq ? SZ_4 :
                hi24Eq ? SZ_8 :
                hi16Eq ? SZ_16 :
                SZ_32;
endmodule // tpdu_addr_compress

// ### hdl/tpdu_trace_unit.sv
// Purpose: branch, window and software trace out of a nibble trace port, plus
//   event- or run-to-break-bounded performance measurement and delayed event halt
// Assumes: core-side inputs on clk; trace port clock arrives asynchronous
// Notes: one record in flight, events offered while busy are dropped and counted
//
// Added by the designer: the address-and-strobe port and the register offsets.
module tpdu_trace_unit
  import tpdu_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire tpdu_branch_t branchIn,
  input wire tpdu_bus_t mBusIn,
  input wire tpdu_bus_t iBusIn,
  input wire logic swTraceValid,
  input wire logic [31:0] swTracePc,
  input wire logic [31:0] swTraceReg,
  input wire logic event1Match,
  input wire logic event2Match,
  input wire logic userRunStart,
  input wire logic breakIn,
  input wire logic breakUnaffected,
  input wire logic instrRetire,
  input wire logic traceClk,
  output logic [3:0] traceData,
  output logic traceSync,
  output logic haltReq
);
  // registers
  logic [8:0] ctrl_r;
  logic [31:0] winStart_r [2];
  logic [31:0] winEnd_r [2];
  logic [2:0] winCfg_r [2];
  logic [31:0] perfCount_r;
  logic perfActive_r;
  logic [15:0] lostCount_r;
  logic clkFast_r;
  logic [31:0] regRdata_r;
  // trace port state
  logic tclkMeta_r, tclkSync_r, tclkPrev_r;
  logic [7:0] cycSinceRise_r;
  logic busy_r;
  logic headerPending_r;
  tpdu_rec_t rec_r;
  logic [4:0] nibLeft_r;
  logic [3:0] traceData_r;
  logic traceSync_r;
  // compression references
  logic [31:0] brRef_r, winRef_r;
  logic brRefValid_r, winRefValid_r;
  // halt
  logic haltPending_r, haltReq_r;
  logic [1:0] haltCnt_r;

  // register decode
  function automatic logic winSel(input logic [7:0] a, input int ch, input int idx);
    winSel = a == 8'(REG_WIN_BASE + ch * REG_WIN_STRIDE + idx * 4);
  endfunction
  wire logic ctrlWr = regWr && regAddr == REG_CTRL;
  wire logic statusWr = regWr && regAddr == REG_STATUS;
  wire logic perfClear = ctrlWr && regWdata[CTRL_PERF_CLEAR];
  wire logic profileOn = ctrl_r[CTRL_PROFILE_ON];
  wire tpdu_mode_t measMode = tpdu_mode_t'(ctrl_r[CTRL_MODE_LO +: 2]);

  // trace clock edge detection on synchronised samples
  wire logic tclkFall = tclkPrev_r && !tclkSync_r;
  wire logic tclkRise = !tclkPrev_r && tclkSync_r;

  // window capture per channel
  function automatic logic winHit(input tpdu_bus_t b, input logic [31:0] lo,
                                  input logic [31:0] hi, input logic [2:0] cfg);
    winHit = b.valid && b.addr >= lo && b.addr <= hi &&
             (b.write ? cfg[WCFG_WRITE] : cfg[WCFG_READ]);
  endfunction
  logic [1:0] winOffer;
  logic [31:0] winAddr [2];
  for (genvar ch = 0; ch < 2; ch++) begin : g_win
    wire logic useIbus = winCfg_r[ch][WCFG_IBUS];
    wire logic chEn = ctrl_r[CTRL_WIN_A_EN + ch];
    // memory bus keeps hits, system bus drops them
    wire logic mHit = winHit(mBusIn, winStart_r[ch], winEnd_r[ch], winCfg_r[ch]);
    wire logic iHit = winHit(iBusIn, winStart_r[ch], winEnd_r[ch], winCfg_r[ch]) &&
                      !iBusIn.cacheHit;
    assign winOffer[ch] = chEn && (useIbus ? iHit : mHit);
    assign winAddr[ch] = useIbus ? iBusIn.addr : mBusIn.addr;
  end

  // branch offer: affected kinds lose their record under an immediate break
  wire logic brAffected = branchIn.kind != BR_DELAYED;
  wire logic brDrop = breakIn && !breakUnaffected && brAffected;
  wire logic brOffer = ctrl_r[CTRL_BRANCH_EN] && branchIn.valid && !brDrop;
  wire logic [31:0] brAddr = branchIn.completionExc ? branchIn.nextAddr
                                                    : branchIn.srcAddr;
  wire logic swOffer = ctrl_r[CTRL_SW_EN] && swTraceValid;

  // compression
  tpdu_size_t brSize, winSize;
  wire logic winPickA = winOffer[0];
  wire logic [31:0] winPickAddr = winPickA ? winAddr[0] : winAddr[1];
  tpdu_addr_compress u_br_comp (
    .addr(brAddr),
    .refAddr(brRef_r),
    .refValid(brRefValid_r),
    .size(brSize)
  );
  tpdu_addr_compress u_win_comp (
    .addr(winPickAddr),
    .refAddr(winRef_r),
    .refValid(winRefValid_r),
    .size(winSize)
  );

  // record selection, fixed priority within one cycle
  wire logic anyWin = |winOffer;
  wire logic anyOffer = brOffer || anyWin || swOffer;
  wire logic [2:0] offerCount = 3'(brOffer) + 3'(winOffer[0]) + 3'(winOffer[1]) +
                                3'(swOffer);
  wire logic loadRec = anyOffer && !busy_r && !profileOn;
  wire logic loadBr = loadRec && brOffer;
  wire logic loadWin = loadRec && !brOffer && anyWin;
  tpdu_rec_t recNew;
  assign recNew = brOffer ? '{REC_BRANCH, brSize, {32'h0000_0000, brAddr}} :
                  anyWin ? '{winPickA ? REC_WIN_A : REC_WIN_B, winSize,
                             {32'h0000_0000, winPickAddr}} :
                  '{REC_SOFT, SZ_32, {swTraceReg, swTracePc}};
  wire logic [4:0] recNibbles = (!brOffer && !anyWin) ? SW_NIBBLES
                                                      : sizeNibbles(recNew.size);
  wire logic [2:0] lostInc = loadRec ? offerCount - 3'h1 : offerCount;
  wire logic lostEvent = anyOffer && (!loadRec || offerCount > 3'h1);

  // performance period
  logic perfActive_nxt;
  always_comb begin
    perfActive_nxt = perfActive_r;
    case (measMode)
      MEAS_EVENT2_TO_EVENT1: begin
        if (!perfActive_r && event2Match) perfActive_nxt = 1'b1;
        else if (perfActive_r && event1Match) perfActive_nxt = 1'b0;
      end
      MEAS_EVENT1_TO_EVENT2: begin
        if (!perfActive_r && event1Match) perfActive_nxt = 1'b1;
        else if (perfActive_r && event2Match) perfActive_nxt = 1'b0;
      end
      default: begin
        if (breakIn) perfActive_nxt = 1'b0;
        else if (userRunStart) perfActive_nxt = 1'b1;
      end
    endcase
  end

  // read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (regAddr)
      REG_CTRL: rdMux = {24'h0, ctrl_r[7:0]};
      REG_STATUS: rdMux = {28'h0, haltReq_r, clkFast_r, busy_r, perfActive_r};
      REG_PERF_COUNT: rdMux = perfCount_r;
      REG_LOST_COUNT: rdMux = {16'h0, lostCount_r};
      default: begin
        for (int ch = 0; ch < 2; ch++) begin
          if (winSel(regAddr, ch, 0)) rdMux = winStart_r[ch];
          if (winSel(regAddr, ch, 1)) rdMux = winEnd_r[ch];
          if (winSel(regAddr, ch, 2)) rdMux = {29'h0, winCfg_r[ch]};
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= {1'b0, CTRL_RESET};
      regRdata_r <= 32'h0000_0000;
    end else begin
      if (ctrlWr) ctrl_r <= {1'b0, regWdata[7:0]};
      regRdata_r <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_wreg
    always_ff @(posedge clk) begin
      if (srst) begin
        winStart_r[ch] <= WIN_ADDR_RESET;
        winEnd_r[ch] <= WIN_ADDR_RESET;
        winCfg_r[ch] <= WIN_CFG_RESET;
      end else begin
        if (regWr && winSel(regAddr, ch, 0)) winStart_r[ch] <= regWdata;
        if (regWr && winSel(regAddr, ch, 1)) winEnd_r[ch] <= regWdata;
        if (regWr && winSel(regAddr, ch, 2)) winCfg_r[ch] <= regWdata[2:0];
      end
    end
  end

  // measurement and lost counters
  always_ff @(posedge clk) begin
    if (srst) begin
      perfActive_r <= 1'b0;
      perfCount_r <= 32'h0000_0000;
      lostCount_r <= 16'h0000;
    end else begin
      perfActive_r <= perfActive_nxt;
      if (perfClear) perfCount_r <= 32'h0000_0000;
      else if (perfActive_r && perfCount_r != 32'hFFFF_FFFF) perfCount_r <= perfCount_r + 32'h1;
      if (lostEvent && lostCount_r < 16'hFFFC) lostCount_r <= lostCount_r + 16'(lostInc);
    end
  end

  // trace clock sampling and rate check; set wins over write-one clear
  always_ff @(posedge clk) begin
    if (srst) begin
      tclkMeta_r <= 1'b0;
      tclkSync_r <= 1'b0;
      tclkPrev_r <= 1'b0;
      cycSinceRise_r <= 8'hFF;
      clkFast_r <= 1'b0;
    end else begin
      tclkMeta_r <= traceClk;
      tclkSync_r <= tclkMeta_r;
      tclkPrev_r <= tclkSync_r;
      if (tclkRise) cycSinceRise_r <= 8'h01;
      else if (cycSinceRise_r != 8'hFF) cycSinceRise_r <= cycSinceRise_r + 8'h01;
      if (tclkRise && cycSinceRise_r < TRACE_MIN_PERIOD_CYC) clkFast_r <= 1'b1;
      else if (statusWr && regWdata[STAT_CLK_FAST]) clkFast_r <= 1'b0;
    end
  end

  // record shifter, data change on the falling edge for capture on the rising
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      headerPending_r <= 1'b0;
      rec_r <= '0;
      nibLeft_r <= 5'h00;
      traceData_r <= 4'h0;
      traceSync_r <= 1'b0;
    end else if (profileOn) begin
      busy_r <= 1'b0;
      headerPending_r <= 1'b0;
      traceData_r <= 4'h0;
      traceSync_r <= 1'b0;
    end else begin
      if (loadRec) begin
        busy_r <= 1'b1;
        headerPending_r <= 1'b1;
        rec_r <= recNew;
        nibLeft_r <= recNibbles;
      end else if (tclkFall && busy_r) begin
        if (headerPending_r) begin
          headerPending_r <= 1'b0;
          traceData_r <= {rec_r.rtype, rec_r.size};
          traceSync_r <= 1'b1;
        end else begin
          traceData_r <= rec_r.payload[3:0];
          traceSync_r <= 1'b0;
          rec_r.payload <= {4'h0, rec_r.payload[63:4]};
          nibLeft_r <= nibLeft_r - 5'h01;
          if (nibLeft_r == 5'h01) busy_r <= 1'b0;
        end
      end else if (tclkFall) begin
        traceData_r <= 4'h0;
        traceSync_r <= 1'b0;
      end
    end
  end

  // compression references follow what was actually sent
  always_ff @(posedge clk) begin
    if (srst) begin
      brRef_r <= 32'h0000_0000;
      winRef_r <= 32'h0000_0000;
      brRefValid_r <= 1'b0;
      winRefValid_r <= 1'b0;
    end else begin
      if (loadBr) begin
        brRef_r <= brAddr;
        brRefValid_r <= 1'b1;
      end
      if (loadWin) begin
        winRef_r <= winPickAddr;
        winRefValid_r <= 1'b1;
      end
    end
  end

  // event halt after the retirement of further instructions
  always_ff @(posedge clk) begin
    if (srst) begin
      haltPending_r <= 1'b0;
      haltCnt_r <= 2'h0;
      haltReq_r <= 1'b0;
    end else if (breakIn) begin
      haltPending_r <= 1'b0;
      haltReq_r <= 1'b0;
    end else if (!haltPending_r && !haltReq_r && ctrl_r[CTRL_HALT_ON_EVENT] &&
                 (event1Match || event2Match)) begin
      haltPending_r <= 1'b1;
      haltCnt_r <= HALT_DELAY_INSTR;
    end else if (haltPending_r && instrRetire) begin
      haltCnt_r <= haltCnt_r - 2'h1;
      if (haltCnt_r == 2'h1) begin
        haltPending_r <= 1'b0;
        haltReq_r <= 1'b1;
      end
    end
  end

  assign regRdata = regRdata_r;
  assign traceData = traceData_r;
  assign traceSync = traceSync_r;
  assign haltReq = haltReq_r;
endmodule // tpdu_trace_unit

// ### test/tpdu_trace_unit_sva.sv
// Purpose: port checks of the trace and measurement unit
// Assumes: one clk domain, srst synchronous
// Notes: control shadow is rebuilt from register writes
module tpdu_trace_unit_sva
  import tpdu_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic event1Match,
  input wire logic event2Match,
  input wire logic breakIn,
  input wire logic instrRetire,
  input wire logic [3:0] traceData,
  input wire logic traceSync,
  input wire logic haltReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] ctrl_r;
  logic [1:0] retCnt_r;
  wire ctrlWr = regWr && regAddr == REG_CTRL;
  wire anyEvt = event1Match || event2Match;
  wire profOn = ctrl_r[CTRL_PROFILE_ON];
  always_ff @(posedge clk) begin
    if (srst) ctrl_r <= CTRL_RESET;
    else if (ctrlWr) ctrl_r <= regWdata[7:0];
  end
  // retires seen since the last event match, saturating
  always_ff @(posedge clk) begin
    if (srst || anyEvt) retCnt_r <= 2'h0;
    else if (instrRetire && retCnt_r != 2'h3) retCnt_r <= retCnt_r + 2'h1;
  end
  property p_rdIdle;
    !$past(regRd) |-> regRdata == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data not zero outside read");
  property p_ctrlRead;
    $past(regRd) && $past(regAddr) == REG_CTRL |-> regRdata == {24'h0, ctrl_r};
  endproperty
  a_ctrlRead: assert property (p_ctrlRead) else $error("control readback wrong");
  property p_prof;
    profOn && $past(profOn) |-> traceData == 4'h0 && !traceSync;
  endproperty
  a_prof: assert property (p_prof) else $error("trace port active while profiling");
  property p_haltRet;
    $rose(haltReq) |-> retCnt_r >= 2'h2 && ctrl_r[CTRL_HALT_ON_EVENT];
  endproperty
  a_haltRet: assert property (p_haltRet) else $error("halt before two retires");
  property p_haltClr;
    breakIn |=> !haltReq;
  endproperty
  a_haltClr: assert property (p_haltClr) else $error("halt request kept after break");
  property p_haltHold;
    haltReq && !breakIn |=> haltReq;
  endproperty
  a_haltHold: assert property (p_haltHold) else $error("halt request dropped early");
  property p_syncHold;
    $rose(traceSync) |-> traceSync [*8];
  endproperty
  a_syncHold: assert property (p_syncHold) else $error("header nibble too short");
  property p_softSize;
    traceSync && traceData[3:2] == REC_SOFT |-> traceData[1:0] == SZ_32;
  endproperty
  a_softSize: assert property (p_softSize) else $error("software record size wrong");
endmodule // tpdu_trace_unit_sva

bind tpdu_trace_unit tpdu_trace_unit_sva chk_u (.clk(clk), .srst(srst), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .event1Match(event1Match), .event2Match(event2Match), .breakIn(breakIn),
  .instrRetire(instrRetire), .traceData(traceData), .traceSync(traceSync), .haltReq(haltReq));

// ### test/tpdu_emu_model.sv
// Purpose: emulator side capture of the nibble trace port
// Assumes: header flagged by traceSync, payload low nibble first
// Notes: trace clock runs free, record strobe lasts one trace period
module tpdu_emu_model
  import tpdu_pkg::*;
(
  output logic traceClk,
  input wire logic [3:0] traceData,
  input wire logic traceSync,
  output logic recStb,
  output logic [67:0] rec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hdr = 4'h0;
  logic [4:0] need = 5'h0;
  logic [4:0] got = 5'h0;
  logic [63:0] pay = 64'h0;
  // debug clock starts at 1.25 MHz, under the core clock, and returns there on reset
  localparam int DBG_TCK_START_KHZ = 1250;
  // user stack option is off by default, so a break takes no stack bytes
  localparam int BREAK_STACK_BYTES = 0;
  // an odd breakpoint request is placed on the even address below it
  function automatic logic [31:0] bpPlace(input logic [31:0] ad);
    return {ad[31:1], 1'b0};
  endfunction
  initial begin
    traceClk = 1'b0;
    recStb = 1'b0;
    #3;
    forever #80 traceClk = ~traceClk;
  end
  always @(posedge traceClk) begin
    recStb <= 1'b0;
    if (traceSync) begin
      hdr <= traceData;
      need <= traceData[3:2] == REC_SOFT ? 5'h10 : 5'h1 << traceData[1:0];
      got <= 5'h0;
      pay <= 64'h0;
    end else if (got < need) begin
      pay[got*4 +: 4] <= traceData;
      got <= got + 5'h1;
      recStb <= got + 5'h1 == need;
    end
  end
  assign rec = {hdr, pay};
endmodule // tpdu_emu_model

// ### test/tpdu_trace_unit_tb.sv
// Purpose: self-checking bench of the trace and measurement unit
// Assumes: emulator model clocks and captures the trace port
// Notes: drivers queue expected records, a monitor matches captures
module tpdu_trace_unit_tb
  import tpdu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic swV = 1'b0;
  logic [31:0] swPc = 32'h0;
  logic [31:0] swReg = 32'h0;
  tpdu_branch_t br = '0;
  tpdu_bus_t mb = '0;
  tpdu_bus_t ib = '0;
  // ev1, ev2, run start, break, unaffected, retire
  logic [5:0] pu = 6'h0;
  logic [31:0] regRdata;
  logic [3:0] traceData;
  logic traceSync, haltReq, traceClk, recStb, rdSeen;
  logic [67:0] rec;
  int n_fail = 0;
  int samples_checked = 0;
  int seed = 61992;
  int i, m;
  logic [67:0] expQ[$];
  logic [31:0] rdQ[$], mskQ[$];
  logic [32:0] brRef = '0, winRef = '0;
  logic [31:0] a, b, v;
  logic [37:0] o;
  logic [31:0] tbl [5] = '{32'h0, 32'h4, 32'h40, 32'h4000, 32'h4000_0000};
  logic [37:0] ofs [8] = '{{6'h29, 32'h1234}, {6'h02, 32'h1238}, {6'h07, 32'h8010},
    {6'h36, 32'h8014}, {6'h00, 32'h2000}, {6'h34, 32'h8018}, {6'h04, 32'h8020},
    {6'h2A, 32'h1240}};
  logic [5:0] opn [4] = '{6'h04, 6'h02, 6'h01, 6'h04};
  logic [5:0] cls [4] = '{6'h08, 6'h01, 6'h02, 6'h08};
  always #5 clk = ~clk;
  tpdu_trace_unit dut_u (.clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .branchIn(br), .mBusIn(mb),
    .iBusIn(ib), .swTraceValid(swV), .swTracePc(swPc), .swTraceReg(swReg),
    .event1Match(pu[0]), .event2Match(pu[1]), .userRunStart(pu[2]), .breakIn(pu[3]),
    .breakUnaffected(pu[4]), .instrRetire(pu[5]), .traceClk(traceClk),
    .traceData(traceData), .traceSync(traceSync), .haltReq(haltReq));
  tpdu_emu_model emu_u (.traceClk(traceClk), .traceData(traceData), .traceSync(traceSync),
    .recStb(recStb), .rec(rec));
  task automatic chk(input logic [67:0] got, input logic [67:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  initial rdSeen = 1'b0;
  always @(posedge clk) begin
    if (rdSeen) chk(68'(regRdata & mskQ.pop_front()), 68'(rdQ.pop_front()));
    rdSeen <= regRd;
  end
  always @(negedge traceClk) begin
    if (recStb) chk(rec, expQ.size() > 0 ? expQ.pop_front() : ~rec);
  end
  function automatic logic [67:0] mk(input logic [1:0] t, input logic [31:0] ad,
                                     inout logic [32:0] r);
    logic [1:0] s;
    s = !r[32] ? 2'h3 : ad[31:4] == r[31:4] ? 2'h0 : ad[31:8] == r[31:8] ? 2'h1 :
      ad[31:16] == r[31:16] ? 2'h2 : 2'h3;
    r = {1'b1, ad};
    return {t, s, 32'h0, ad & (s == 2'h0 ? 32'hF : s == 2'h1 ? 32'hFF :
      s == 2'h2 ? 32'hFFFF : 32'hFFFF_FFFF)};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    regAddr <= ad;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk) regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] mk2, input logic [31:0] e);
    mskQ.push_back(mk2);
    rdQ.push_back(e);
    regAddr <= ad;
    regRd <= 1'b1;
    @(posedge clk) regRd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [5:0] p);
    pu <= p;
    @(posedge clk) pu <= 6'h0;
    @(posedge clk);
  endtask
  task automatic hchk(input logic e);
    @(negedge clk);
    chk(68'(haltReq), 68'(e));
    @(posedge clk);
  endtask
  task automatic brOff(input tpdu_brkind_t k, input logic x, input logic [31:0] s,
                       input logic [31:0] n, input logic [5:0] p);
    br <= {1'b1, k, x, s, n};
    pu <= p;
    @(posedge clk);
    br.valid <= 1'b0;
    pu <= 6'h0;
    @(posedge clk);
  endtask
  task automatic drain;
    for (int j = 0; j < 900 && expQ.size() > 0; j++) @(posedge clk);
    if (expQ.size() > 0) chk(68'h0, 68'h1);
    repeat (200) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    v = $random(seed);
    rd(REG_CTRL, 32'hFFFF_FFFF, 32'h0);
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0);
    wr(REG_CTRL, {23'h0, v[8], 4'h0, v[3:0]});
    rd(REG_CTRL, 32'hFFFF_FFFF, {28'h0, v[3:0]});
    $display("test registers done");
    wr(REG_CTRL, 32'h1);
    b = $random(seed);
    for (i = 0; i < 5; i++) begin
      a = b ^ tbl[i];
      expQ.push_back(mk(REC_BRANCH, a, brRef));
      brOff(tpdu_brkind_t'(i[1:0]), 1'b0, a, $random(seed), 6'h0);
      drain;
    end
    expQ.push_back(mk(REC_BRANCH, a ^ 32'h2, brRef));
    brOff(BR_EXCEPTION, 1'b1, $random(seed), a ^ 32'h2, 6'h0);
    drain;
    brOff(BR_NON_DELAYED, 1'b0, a, a, 6'h08);
    drain;
    expQ.push_back(mk(REC_BRANCH, a ^ 32'h80, brRef));
    brOff(BR_TRAP_ALWAYS, 1'b0, a ^ 32'h80, a, 6'h18);
    drain;
    $display("test branch done");
    wr(REG_WIN_BASE, 32'h1000);
    wr(REG_WIN_BASE + 8'h04, 32'h1FFF);
    wr(REG_WIN_BASE + 8'h08, 32'h2);
    wr(REG_WIN_BASE + 8'h0C, 32'h8000);
    wr(REG_WIN_BASE + 8'h10, 32'h8FFF);
    wr(REG_WIN_BASE + 8'h14, 32'h7);
    wr(REG_CTRL, 32'h6);
    for (i = 0; i < 8; i++) begin
      o = ofs[i];
      if (i == 6) wr(REG_CTRL, 32'h2);
      if (i == 7) wr(REG_WIN_BASE + 8'h08, 32'h4);
      if (o[37]) expQ.push_back(mk(o[36:35], o[31:0], winRef));
      if (o[34]) ib <= {1'b1, o[33:0]};
      else mb <= {1'b1, o[33:0]};
      @(posedge clk);
      ib.valid <= 1'b0;
      mb.valid <= 1'b0;
      drain;
    end
    rd(REG_WIN_BASE + 8'h08, 32'h7, 32'h4);
    $display("test window done");
    wr(REG_CTRL, 32'h8);
    for (i = 0; i < 2; i++) begin
      a = $random(seed);
      b = $random(seed);
      expQ.push_back({REC_SOFT, SZ_32, b, a});
      swPc <= a;
      swReg <= b;
      swV <= 1'b1;
      @(posedge clk) swV <= 1'b0;
      drain;
    end
    wr(REG_CTRL, 32'h19);
    brOff(BR_DELAYED, 1'b0, b, b, 6'h0);
    drain;
    rd(REG_LOST_COUNT, 32'hFFFF, 32'h1);
    $display("test software and profiling done");
    for (m = 0; m < 4; m++) begin
      wr(REG_CTRL, m << 5);
      pulse(cls[m]);
      rd(REG_STATUS, 32'h1, 32'h0);
      pulse(opn[m]);
      rd(REG_STATUS, 32'h1, 32'h1);
      pulse(cls[m]);
      rd(REG_STATUS, 32'h1, 32'h0);
    end
    $display("test measurement done");
    wr(REG_CTRL, 32'h80);
    pulse(6'h01);
    pulse(6'h20);
    hchk(1'b0);
    pulse(6'h20);
    hchk(1'b1);
    pulse(6'h08);
    hchk(1'b0);
    $display("test halt done");
    close_out;
  end
endmodule // tpdu_trace_unit_tb
